// [rtl/sldds_lane_counter.sv]
`timescale 1ns/10ps
module sldds_lane_counter
  import sldds_pkg::*;
#(
  parameter int CNT_W = SLDDS_CNT_W
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Error events
  input  wire logic             error_pulse,
  input  wire logic             count_clear,
  input  wire logic [CNT_W-1:0] threshold,
  // Status
  output logic      [CNT_W-1:0] error_count,
  output logic                  over_threshold
);

  logic [CNT_W-1:0] next_error_count;

  // ****************************************
  // Saturating counter
  // ****************************************
  // per-lane counting
  always_comb begin
    next_error_count = error_count;
    if (count_clear) begin
      next_error_count = CNT_W'(COUNT_RESET);
    end else if (error_pulse && (error_count != {CNT_W{1'b1}})) begin
      next_error_count = error_count + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      error_count <= CNT_W'(COUNT_RESET);
    end else begin
      error_count <= next_error_count;
    end
  end

  assign over_threshold = (error_count >= threshold);

  // ****************************************
  // Checks
  // ****************************************
  AST_CNT_STEP: assert property (
    @(posedge core_clk) disable iff (reset)
    (error_pulse && !count_clear && error_count != {CNT_W{1'b1}})
      |=> (error_count == $past(error_count) + CNT_W'(1)))
    else $error("lane counter did not advance on an error");

  AST_CNT_HOLD: assert property (
    @(posedge core_clk) disable iff (reset)
    (count_clear || (error_pulse && error_count == {CNT_W{1'b1}}) || !error_pulse)
      |=> (error_count == (($past(count_clear)) ? CNT_W'(COUNT_RESET) : $past(error_count))))
    else $error("lane counter moved without an error or clear");

endmodule

// [rtl/sldds_pkg.sv]
// What this block does
// - Each lane has one deskew result bit at the position of its lane number, 1 for achieved.
// - One read-only 8-bit register holds one bad-disparity bit per lane, bit n for lane n.
// - A lane's disparity bit is 1 when its error count is at least the threshold, else 0.
// - All deskew and disparity bits are 0 after reset and writes to them change nothing.
package sldds_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int          SLDDS_LANES   = 8;
  localparam int          SLDDS_ADDR_W  = 12;
  localparam int          SLDDS_DATA_W  = 8;
  localparam int          SLDDS_CNT_W   = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ALIGN_FLAGS_OFFSET     = 12'h46c;
  localparam logic [11:0] DISPARITY_FLAGS_OFFSET = 12'h46d;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  FLAGS_RESET   = 8'h00;
  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  COUNT_MAX     = 8'hff;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

endpackage

// [rtl/sldds_top.sv]
`timescale 1ns/10ps
module sldds_top
  import sldds_pkg::*;
#(
  parameter int LANES = SLDDS_LANES
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Configuration port
  input  wire logic [SLDDS_ADDR_W-1:0] cfg_addr,
  input  wire logic                    cfg_rd,
  input  wire logic                    cfg_wr,
  input  wire logic [SLDDS_DATA_W-1:0] cfg_wdata,
  output logic      [SLDDS_DATA_W-1:0] cfg_rdata,
  output logic                         cfg_rvalid,
  // Lane status from the deserializers
  input  wire logic [LANES-1:0]        lane_deskew_ok,
  input  wire logic [LANES-1:0]        lane_disparity_err,
  input  wire logic                    err_count_clear,
  // Link settings
  input  wire logic [SLDDS_CNT_W-1:0]  lane_error_threshold,
  input  wire logic                    skip_initial_alignment_sequence,
  // Status
  output logic      [LANES-1:0]        lane_alignment_result_flags,
  output logic      [LANES-1:0]        lane_disparity_error_flags,
  output logic                         align_flags_meaningful
);

  logic [LANES-1:0]        next_align_flags;
  logic [LANES-1:0]        next_disp_flags;
  logic [LANES-1:0]        lane_over;
  logic [SLDDS_CNT_W-1:0]  lane_count [LANES];
  logic [SLDDS_DATA_W-1:0] next_rdata;
  logic                    next_rvalid;
  logic                    next_meaningful;

  // ****************************************
  // Per-lane error counters
  // ****************************************
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    sldds_lane_counter #(
      .CNT_W (SLDDS_CNT_W)
    ) u_cnt (
      .core_clk       (core_clk),
      .reset          (reset),
      .error_pulse    (lane_disparity_err[g]),
      .count_clear    (err_count_clear),
      .threshold      (lane_error_threshold),
      .error_count    (lane_count[g]),
      .over_threshold (lane_over[g])
    );
  end

  // ****************************************
  // Status flags
  // ****************************************
  always_comb begin
    // bit n follows lane n deskew
    next_align_flags = lane_deskew_ok;
    // bit n flags lane n disparity
    next_disp_flags  = lane_over;
    // flags carry no meaning when alignment is skipped
    next_meaningful  = !skip_initial_alignment_sequence;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lane_alignment_result_flags <= LANES'(FLAGS_RESET);
      lane_disparity_error_flags  <= LANES'(FLAGS_RESET);
      align_flags_meaningful      <= 1'b0;
    end else begin
      lane_alignment_result_flags <= next_align_flags;
      lane_disparity_error_flags  <= next_disp_flags;
      align_flags_meaningful      <= next_meaningful;
    end
  end

  // ****************************************
  // Configuration reads
  // ****************************************
  // writes land nowhere, only reads decode
  always_comb begin
    next_rdata  = cfg_rdata;
    next_rvalid = cfg_rd;
    if (cfg_rd) begin
      case (cfg_addr)
        ALIGN_FLAGS_OFFSET:
          next_rdata = SLDDS_DATA_W'(lane_alignment_result_flags);
        DISPARITY_FLAGS_OFFSET:
          next_rdata = SLDDS_DATA_W'(lane_disparity_error_flags);
        default:
          next_rdata = UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_rdata  <= UNMAPPED_DATA;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rdata  <= next_rdata;
      cfg_rvalid <= next_rvalid;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence seq_read_disp;
    cfg_rd && (cfg_addr == DISPARITY_FLAGS_OFFSET);
  endsequence

  sequence seq_read_align;
    cfg_rd && (cfg_addr == ALIGN_FLAGS_OFFSET);
  endsequence

  AST_ALIGN_TRACK: assert property (
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> (lane_alignment_result_flags == $past(lane_deskew_ok)))
    else $error("deskew flags do not follow lane deskew results");

  AST_DISP_THRESH: assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 (lane_disparity_error_flags[0] == ($past(lane_count[0]) >= $past(lane_error_threshold))))
    else $error("lane 0 disparity flag disagrees with count and threshold");

  AST_DISP_MAP: assert property (
    @(posedge core_clk) disable iff (reset)
    ##1 (lane_disparity_error_flags == $past(lane_over)))
    else $error("disparity flags not mapped lane for lane");

  AST_READ_DISP: assert property (
    @(posedge core_clk) disable iff (reset)
    seq_read_disp |=> (cfg_rvalid && cfg_rdata == $past(lane_disparity_error_flags)))
    else $error("disparity register read returned wrong data");

  AST_READ_ALIGN: assert property (
    @(posedge core_clk) disable iff (reset)
    seq_read_align |=> (cfg_rvalid && cfg_rdata == $past(lane_alignment_result_flags)))
    else $error("deskew register read returned wrong data");

  AST_RESET_ZERO: assert property (
    @(posedge core_clk)
    $fell(reset) |-> (lane_alignment_result_flags == '0 && lane_disparity_error_flags == '0))
    else $error("status flags not zero after reset");

  AST_WRITE_IGNORED: assert property (
    @(posedge core_clk) disable iff (reset)
    (cfg_wr && !cfg_rd) |=> (!cfg_rvalid && cfg_rdata == $past(cfg_rdata)))
    else $error("a write disturbed the read side");

  AST_RESET_PORT: assert property (
    @(posedge core_clk)
    $fell(reset) |-> (!cfg_rvalid && cfg_rdata == UNMAPPED_DATA
                      && !align_flags_meaningful))
    else $error("read port not idle after reset");

  sequence seq_read_other;
    cfg_rd && (cfg_addr != ALIGN_FLAGS_OFFSET) && (cfg_addr != DISPARITY_FLAGS_OFFSET);
  endsequence

  sequence seq_single_read;
    cfg_rd ##1 !cfg_rd;
  endsequence

  AST_READ_ANSWER: assert property (
    @(posedge core_clk) disable iff (reset)
    cfg_rd |=> cfg_rvalid)
    else $error("a read got no answer strobe");

  AST_READ_UNMAPPED: assert property (
    @(posedge core_clk) disable iff (reset)
    seq_read_other |=> (cfg_rvalid && cfg_rdata == UNMAPPED_DATA))
    else $error("an unmapped read returned data");

  AST_RVALID_PULSE: assert property (
    @(posedge core_clk) disable iff (reset)
    seq_single_read |=> !cfg_rvalid)
    else $error("read strobe stood longer than one cycle");

  AST_RDATA_HOLD: assert property (
    @(posedge core_clk) disable iff (reset)
    !cfg_rd |=> $stable(cfg_rdata))
    else $error("read data moved without a read");

  AST_SKIP_MARK: assert property (
    @(posedge core_clk) disable iff (reset)
    1'b1 |=> (align_flags_meaningful == !$past(skip_initial_alignment_sequence)))
    else $error("deskew validity mark does not follow the skip option");

  // ****************************************
  // Per-lane checks
  // ****************************************
  for (genvar k = 0; k < LANES; k++) begin : g_lane_chk
    AST_LANE_ALIGN: assert property (
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (lane_alignment_result_flags[k] == $past(lane_deskew_ok[k])))
      else $error("a deskew flag sits at the wrong lane position");

    AST_LANE_THRESH: assert property (
      @(posedge core_clk) disable iff (reset)
      1'b1 |=> (lane_disparity_error_flags[k] ==
                ($past(lane_count[k]) >= $past(lane_error_threshold))))
      else $error("a lane disparity flag disagrees with its count");

    AST_LANE_CLEAR: assert property (
      @(posedge core_clk) disable iff (reset)
      err_count_clear |=> (lane_count[k] == COUNT_RESET))
      else $error("a lane counter survived the clear");

    AST_LANE_SATURATE: assert property (
      @(posedge core_clk) disable iff (reset)
      (lane_count[k] == COUNT_MAX && !err_count_clear) |=> (lane_count[k] == COUNT_MAX))
      else $error("a saturated lane counter wrapped");
  end

endmodule

// [sim/sldds_tx_model.sv]
`timescale 1ns/10ps
module sldds_tx_model
  import sldds_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Burst request
  input  wire logic       start,
  input  wire logic [7:0] lanes,
  input  wire logic [7:0] count,
  // Lane error pulses
  output logic            busy,
  output logic      [7:0] disp_err
);
  logic [7:0] left;
  logic [7:0] lanes_q;

  // One error pulse per cycle on each chosen lane
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      left    <= 8'h00;
      lanes_q <= 8'h00;
    end else if (start) begin
      left    <= count;
      lanes_q <= lanes;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign busy     = (left != 8'h00);
  assign disp_err = busy ? lanes_q : 8'h00;
endmodule

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
  import sldds_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [11:0] cfg_addr = 12'h000;
  logic        cfg_rd = 1'b0;
  logic        cfg_wr = 1'b0;
  logic [7:0]  cfg_wdata = 8'h00;
  logic [7:0]  cfg_rdata, lane_alignment_result_flags, lane_disparity_error_flags;
  logic        cfg_rvalid, align_flags_meaningful, busy, start = 1'b0;
  logic [7:0]  lane_deskew_ok = 8'hff;
  logic [7:0]  lane_disparity_err, lanes = 8'h00, count = 8'h00;
  logic        err_count_clear = 1'b0;
  logic [7:0]  lane_error_threshold = 8'h01;
  logic        skip_initial_alignment_sequence = 1'b0;
  int          num_errors = 0;
  int          n_compared = 0;

  always #12.5 core_clk = ~core_clk;

  sldds_top sldds_top_inst (.core_clk, .reset, .cfg_addr, .cfg_rd, .cfg_wr, .cfg_wdata,
    .cfg_rdata, .cfg_rvalid, .lane_deskew_ok, .lane_disparity_err, .err_count_clear,
    .lane_error_threshold, .skip_initial_alignment_sequence, .lane_alignment_result_flags,
    .lane_disparity_error_flags, .align_flags_meaningful);
  sldds_tx_model sldds_tx_model_inst (.core_clk, .reset, .start, .lanes, .count, .busy,
    .disp_err(lane_disparity_err));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    int i;
    @(posedge core_clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    @(negedge core_clk);
    for (i = 0; i < 4 && cfg_rvalid !== 1'b1; i++) begin
      @(negedge core_clk);
    end
    if (i == 4) begin
      num_errors++;
      close_out();
    end
    chk(e, cfg_rdata);
    @(posedge core_clk);
  endtask

  task automatic tx(input logic [7:0] l, input logic [7:0] c);
    int i;
    @(posedge core_clk);
    start <= 1'b1;
    lanes <= l;
    count <= c;
    @(posedge core_clk);
    start <= 1'b0;
    #1;
    for (i = 0; i < 300 && busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 300) begin
      num_errors++;
      close_out();
    end
    repeat (2) @(posedge core_clk);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    chk(8'h00, lane_alignment_result_flags);
    chk(8'h00, lane_disparity_error_flags);
    reset <= 1'b0;
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    @(posedge core_clk);
    cfg_addr  <= DISPARITY_FLAGS_OFFSET;
    cfg_wdata <= 8'hff;
    cfg_wr    <= 1'b1;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    rdc(12'h123, UNMAPPED_DATA);
    for (int i = 0; i < 8; i++) begin
      lane_deskew_ok <= 8'h01 << i;
      rdc(ALIGN_FLAGS_OFFSET, 8'h01 << i);
    end
    skip_initial_alignment_sequence <= 1'b1;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(8'h00, {7'h00, align_flags_meaningful});
    chk(8'h80, lane_alignment_result_flags);
    @(posedge core_clk);
    skip_initial_alignment_sequence <= 1'b0;
    lane_error_threshold <= 8'h03;
    tx(8'h24, 8'h02);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    chk(8'h01, {7'h00, align_flags_meaningful});
    tx(8'h04, 8'h01);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h04);
    tx(8'h20, 8'h01);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h24);
    lane_error_threshold <= 8'h04;
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    lane_error_threshold <= 8'hff;
    tx(8'h80, 8'hff);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h80);
    tx(8'h80, 8'h02);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h80);
    err_count_clear      <= 1'b1;
    lane_error_threshold <= 8'h01;
    @(posedge core_clk);
    err_count_clear <= 1'b0;
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    tx(8'h5b, 8'h01);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h5b);
    lane_deskew_ok <= 8'hff;
    @(posedge core_clk);
    reset <= 1'b1;
    @(negedge core_clk);
    chk(8'h00, lane_alignment_result_flags);
    chk(8'h00, lane_disparity_error_flags);
    chk(8'h00, cfg_rdata);
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rdc(ALIGN_FLAGS_OFFSET, 8'hff);
    rdc(DISPARITY_FLAGS_OFFSET, 8'h00);
    close_out();
  end
endmodule
